// ---- xcp_defs.svh ----
`ifndef XCP_DEFS_SVH
`define XCP_DEFS_SVH
// register byte offsets
`define XCP_CTRL_OFS   8'h00
`define XCP_DXR_OFS    8'h04
`define XCP_TBASE_OFS  8'h08
`define XCP_STAT_OFS   8'h0c
// control fields
`define XCP_CTRL_IF    0
`define XCP_CTRL_PM    1
`define XCP_CTRL_RST   2'h0
// fixed vectors
`define XCP_VEC_DBG    8'h01
`define XCP_VEC_NMI    8'h02
`define XCP_VEC_BRK    8'h03
`define XCP_VEC_OVF    8'h04
`define XCP_VEC_DF     8'h08
`define XCP_VEC_CSO    8'h09
`define XCP_VEC_RSVD   8'h20
// table entry size as shift: 4 bytes real, 8 bytes protected
`define XCP_ENT_RM_SH  2
`define XCP_ENT_PM_SH  3
// port space
`define XCP_PORT_W     16
`define XCP_PORT_RSV_LO 16'h00f8
`define XCP_PORT_RSV_HI 16'h00ff
`endif

// ---- xcp_pkg.sv ----
`default_nettype none
package xcp_pkg;
    typedef enum logic [2:0] {
        XCP_FAULT,
        XCP_TRAP,
        XCP_ABORT,
        XCP_NMI,
        XCP_MASKABLE_IRQ_IN
    } xcp_cls_t;

    typedef enum logic [1:0] {
        XCP_GATE_INT,
        XCP_GATE_TRAP,
        XCP_GATE_TASK
    } xcp_gate_t;

    typedef struct packed {
        logic [7:0]  vec;
        xcp_cls_t    cls;
        logic        ret_at_instr;
        logic [23:0] entry;
    } xcp_disp_t;
endpackage
`default_nettype wire

// ---- xcp_unit.sv ----
// What this block does
// - 64 KB port space, byte or word ports
// - port number goes straight to address lines
// - port number from immediate or data extension
// - zero-fill address bits above port number
// - space select low during port access
// - 256 vectors, lowest 32 internal
// - faults return to offending instruction incl prefixes
// - traps after instruction; aborts imprecise
// - fixed fault and trap classes by vector
// - vectors 8 and 9 are aborts
// - debug vector 1, trap or fault
// - hardware interrupt after instruction, resume next
// - software interrupts use exception path
// - entry 4 bytes real, 8 protected
// - push return and flags, fetch vector, branch
// - vector sources; non-maskable uses vector 2
// - maskable needs request high and enable set
// - only between instructions or string window
// - gates clear, keep or load enable flag
// - interrupt return restores enable flag
// - non-maskable: no acknowledge, clears enable
// - block during nmi handler, remember one
// - non-maskable dispatched before maskable
`default_nettype none
`include "xcp_defs.svh"
module xcp_unit
    import xcp_pkg::*;
#(
    parameter int NEST = 8
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // core events
    input  wire logic        boundary_i,
    input  wire logic        str_window_i,
    input  wire logic        exc_req_i,
    input  wire logic [7:0]  exc_vec_i,
    input  wire logic        dbg_fault_i,
    input  wire logic        swi_req_i,
    input  wire logic [7:0]  swi_vec_i,
    input  wire logic        interrupt_return_instr_i,
    input  wire xcp_gate_t   gate_i,
    input  wire logic        task_if_i,
    // external requests
    input  wire logic        maskable_irq_in_i,
    input  wire logic        nmi_i,
    input  wire logic [7:0]  ack_vec_i,
    input  wire logic        ack_valid_i,
    // access requests
    input  wire logic        io_req_i,
    input  wire logic        io_use_dx_i,
    input  wire logic [7:0]  io_imm_i,
    input  wire logic        mem_req_i,
    input  wire logic [23:0] mem_addr_i,
    // outputs
    output logic      [23:0] addr_o,
    output logic             mio_o,
    output logic             inta_o,
    output logic             disp_valid_o,
    output xcp_disp_t        disp_o,
    output logic             if_o
);
    typedef enum logic [0:0] {S_IDLE, S_ACK} xcp_state_t;

    logic rst_s1_q;
    logic rst_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_q    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q    <= rst_s1_q;
        end
    end
    wire rst_n = rst_q;

    // classification by vector; swi is always trap
    function automatic xcp_cls_t cls_of(input logic [7:0] v, input logic dbgf);
        xcp_cls_t c;
        c = XCP_FAULT;
        if (v == `XCP_VEC_DF || v == `XCP_VEC_CSO) c = XCP_ABORT;
        else if (v == `XCP_VEC_BRK || v == `XCP_VEC_OVF) c = XCP_TRAP;
        else if (v == `XCP_VEC_DBG) c = dbgf ? XCP_FAULT : XCP_TRAP;
        else if (v == `XCP_VEC_NMI) c = XCP_NMI;
        return c;
    endfunction

    xcp_state_t        st_q;
    logic              if_q;
    logic              pm_q;
    logic [31:0]       dxr_q;
    logic [23:0]       tbase_q;
    logic [NEST-1:0]   ifstk_q;
    logic [4:0]        depth_q;
    logic              nmi_act_q;
    logic              nmi_pend_q;
    logic              nmi_prev_q;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    logic [23:0]       addr_q;
    logic              mio_q;
    logic              inta_q;
    logic              dv_q;
    xcp_disp_t         disp_q;
    logic [7:0]        last_vec_q;

    // apb decode
    wire apb_setup = psel_i && !penable_i;
    wire apb_wr    = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q;
    wire hit_ctrl  = paddr_i == `XCP_CTRL_OFS;
    wire hit_dxr   = paddr_i == `XCP_DXR_OFS;
    wire hit_tbase = paddr_i == `XCP_TBASE_OFS;
    wire hit_stat  = paddr_i == `XCP_STAT_OFS;
    wire hit_any   = hit_ctrl || hit_dxr || hit_tbase || hit_stat;
    wire [31:0] rd_mux =
        hit_ctrl  ? {30'h0, pm_q, if_q} :
        hit_dxr   ? dxr_q :
        hit_tbase ? {8'h00, tbase_q} :
        hit_stat  ? {16'h0, last_vec_q, 1'b0, depth_q, nmi_pend_q, nmi_act_q} :
        32'h0;

    // port address: immediate or low half of data extension register
    wire [`XCP_PORT_W-1:0] port_num =
        io_use_dx_i ? dxr_q[`XCP_PORT_W-1:0] : {8'h00, io_imm_i};

    // event selection
    wire nmi_edge  = nmi_i && !nmi_prev_q;
    wire nmi_ready = nmi_pend_q && !nmi_act_q;
    wire at_window = boundary_i || str_window_i;
    wire take_exc  = st_q == S_IDLE && exc_req_i;
    wire take_swi  = st_q == S_IDLE && !exc_req_i && swi_req_i;
    wire ext_ok    = st_q == S_IDLE && !exc_req_i && !swi_req_i && at_window;
    wire take_nmi  = ext_ok && nmi_ready;
    wire take_irq  = ext_ok && !nmi_ready && !nmi_act_q
                     && maskable_irq_in_i && if_q;
    wire take_ack  = st_q == S_ACK && ack_valid_i;
    wire do_interrupt_return_instr   = st_q == S_IDLE && interrupt_return_instr_i
                     && !exc_req_i && !swi_req_i && !take_nmi;
    wire dispatch  = take_exc || take_swi || take_nmi || take_ack;

    logic [7:0] d_vec;
    xcp_cls_t   d_cls;
    logic       d_ret;
    always_comb begin
        d_vec = ack_vec_i;
        d_cls = XCP_MASKABLE_IRQ_IN;
        d_ret = 1'b0;
        if (take_exc) begin
            d_vec = exc_vec_i;
            d_cls = cls_of(exc_vec_i, dbg_fault_i);
            d_ret = d_cls == XCP_FAULT;
        end else if (take_swi) begin
            d_vec = swi_vec_i;
            d_cls = XCP_TRAP;
            d_ret = 1'b0;
        end else if (take_nmi) begin
            d_vec = `XCP_VEC_NMI;
            d_cls = XCP_NMI;
            d_ret = 1'b0;
        end
    end

    // real mode 4-byte entries, protected 8-byte
    wire [23:0] d_entry = tbase_q + (pm_q ? ({16'h0, d_vec} << `XCP_ENT_PM_SH)
                                          : ({16'h0, d_vec} << `XCP_ENT_RM_SH));

    // enable flag after entry by gate type
    logic if_entry;
    always_comb begin
        unique case (gate_i)
            XCP_GATE_INT:  if_entry = 1'b0;
            XCP_GATE_TRAP: if_entry = if_q;
            XCP_GATE_TASK: if_entry = task_if_i;
            default:       if_entry = if_q;
        endcase
        if (take_nmi) if_entry = 1'b0;
    end

    wire [4:0] nest_max = 5'(NEST);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= apb_setup;
            pslverr_q <= apb_setup && !hit_any;
            prdata_q  <= (apb_setup && !pwrite_i) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pm_q    <= 1'b0;
            dxr_q   <= 32'h0;
            tbase_q <= 24'h0;
        end else if (apb_wr) begin
            if (hit_ctrl) pm_q <= pwdata_i[`XCP_CTRL_PM];
            if (hit_dxr) dxr_q <= pwdata_i;
            if (hit_tbase) tbase_q <= pwdata_i[23:0];
        end
    end

    // hardware entry and return win over a software write of the flag
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            if_q <= 1'b0;
        end else if (dispatch) begin
            if_q <= if_entry;
        end else if (do_interrupt_return_instr && depth_q != 5'h0) begin
            if_q <= ifstk_q[0];
        end else if (apb_wr && hit_ctrl) begin
            if_q <= pwdata_i[`XCP_CTRL_IF];
        end
    end

    // saved flag stack; deeper nesting than NEST loses the oldest image
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ifstk_q <= '0;
            depth_q <= 5'h0;
        end else if (dispatch) begin
            ifstk_q <= {ifstk_q[NEST-2:0], if_q};
            if (depth_q != nest_max) depth_q <= depth_q + 5'h1;
        end else if (do_interrupt_return_instr && depth_q != 5'h0) begin
            ifstk_q <= {1'b0, ifstk_q[NEST-1:1]};
            depth_q <= depth_q - 5'h1;
        end
    end

    // a new edge wins over the clear at dispatch
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            nmi_prev_q <= 1'b0;
            nmi_pend_q <= 1'b0;
            nmi_act_q  <= 1'b0;
        end else begin
            nmi_prev_q <= nmi_i;
            if (nmi_edge) nmi_pend_q <= 1'b1;
            else if (take_nmi) nmi_pend_q <= 1'b0;
            if (take_nmi) nmi_act_q <= 1'b1;
            else if (do_interrupt_return_instr) nmi_act_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= S_IDLE;
            inta_q <= 1'b0;
        end else begin
            unique case (st_q)
                S_IDLE: if (take_irq) begin
                    st_q   <= S_ACK;
                    inta_q <= 1'b1;
                end
                S_ACK: if (ack_valid_i) begin
                    st_q   <= S_IDLE;
                    inta_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dv_q       <= 1'b0;
            disp_q     <= '0;
            last_vec_q <= 8'h0;
        end else begin
            dv_q <= dispatch;
            if (dispatch) begin
                disp_q     <= '{vec: d_vec, cls: d_cls, ret_at_instr: d_ret,
                                entry: d_entry};
                last_vec_q <= d_vec;
            end
        end
    end

    // port space never translated; upper lines zero
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= 24'h0;
            mio_q  <= 1'b1;
        end else if (io_req_i) begin
            addr_q <= {8'h00, port_num};
            mio_q  <= 1'b0;
        end else if (mem_req_i) begin
            addr_q <= mem_addr_i;
            mio_q  <= 1'b1;
        end
    end

    assign prdata_o     = prdata_q;
    assign pready_o     = pready_q;
    assign pslverr_o    = pslverr_q;
    assign addr_o       = addr_q;
    assign mio_o        = mio_q;
    assign inta_o       = inta_q;
    assign disp_valid_o = dv_q;
    assign disp_o       = disp_q;
    assign if_o         = if_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    property p_io_sel;
        io_req_i |=> !mio_o && addr_o[23:16] == 8'h00;
    endproperty
    a_io_sel: assert property (p_io_sel) else $error("port access bad");

    property p_mem_sel;
        mem_req_i && !io_req_i |=> mio_o && addr_o == $past(mem_addr_i);
    endproperty
    a_mem_sel: assert property (p_mem_sel) else $error("mem access bad");

    property p_dx_port;
        io_req_i && io_use_dx_i |=> addr_o[15:0] == $past(dxr_q[15:0]);
    endproperty
    a_dx_port: assert property (p_dx_port) else $error("dx port bad");

    property p_nmi_vec;
        disp_valid_o && disp_o.cls == XCP_NMI |-> disp_o.vec == 8'h02 && !if_o;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("nmi entry bad");

    sequence s_both_req;
        st_q == S_IDLE && !exc_req_i && !swi_req_i && boundary_i
        && nmi_ready && maskable_irq_in_i && if_q;
    endsequence
    property p_nmi_first;
        s_both_req |=> disp_valid_o && disp_o.vec == 8'h02 && !inta_o;
    endproperty
    a_nmi_first: assert property (p_nmi_first) else $error("nmi not first");

    property p_irq_gate;
        $rose(inta_o) |-> $past(if_q) && $past(maskable_irq_in_i) && !$past(nmi_act_q);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq taken masked");

    sequence s_ack_done;
        inta_o && ack_valid_i;
    endsequence
    property p_ack_vec;
        s_ack_done |=> disp_valid_o && disp_o.vec == $past(ack_vec_i) && !inta_o
                       && disp_o.cls == XCP_MASKABLE_IRQ_IN && !disp_o.ret_at_instr;
    endproperty
    a_ack_vec: assert property (p_ack_vec) else $error("ack vector bad");

    property p_int_gate;
        dispatch && gate_i == XCP_GATE_INT |=> !if_o;
    endproperty
    a_int_gate: assert property (p_int_gate) else $error("if not cleared");

    property p_interrupt_return_instr;
        do_interrupt_return_instr && depth_q != 5'h0 && !dispatch |=> if_o == $past(ifstk_q[0]);
    endproperty
    a_interrupt_return_instr: assert property (p_interrupt_return_instr) else $error("if not restored");

    property p_abort;
        take_exc && (exc_vec_i == `XCP_VEC_DF || exc_vec_i == `XCP_VEC_CSO)
        |=> disp_valid_o && disp_o.cls == XCP_ABORT;
    endproperty
    a_abort: assert property (p_abort) else $error("abort class bad");

    property p_nmi_block;
        nmi_act_q && !interrupt_return_instr_i |=> !(disp_valid_o && disp_o.cls == XCP_NMI);
    endproperty
    a_nmi_block: assert property (p_nmi_block) else $error("nmi nested");

endmodule // xcp_unit
`default_nettype wire

// ---- xcp_pic_model.sv ----
`default_nettype none
module xcp_pic_model (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // acknowledge side
    input  wire logic       inta_i,
    input  wire logic [3:0] dly_i,
    input  wire logic [7:0] vec_i,
    output logic            ack_valid_o,
    output logic      [7:0] ack_vec_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt_q;
    logic       done_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q       <= 4'h0;
            done_q      <= 1'b0;
            ack_valid_o <= 1'b0;
            ack_vec_o   <= 8'h00;
        end else begin
            ack_valid_o <= 1'b0;
            // released bus toggles so a stale vector never looks valid
            ack_vec_o   <= ~ack_vec_o;
            if (!inta_i) begin
                cnt_q  <= 4'h0;
                done_q <= 1'b0;
            end else if (!done_q) begin
                if (cnt_q == dly_i) begin
                    ack_valid_o <= 1'b1;
                    ack_vec_o   <= vec_i;
                    done_q      <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule // xcp_pic_model
`default_nettype wire

// ---- xcp_tb.sv ----
`default_nettype none
`include "xcp_defs.svh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import xcp_pkg::*;
    logic clk_i = '0, arst_n_i = '0, psel_i = '0, penable_i = '0, pwrite_i = '0;
    logic boundary_i = '0, str_window_i = '0, exc_req_i = '0, dbg_fault_i = '0;
    logic swi_req_i = '0, interrupt_return_instr_i = '0, task_if_i = '0;
    logic maskable_irq_in_i = '0, nmi_i = '0, io_req_i = '0, io_use_dx_i = '0, mem_req_i = '0;
    logic [7:0]  paddr_i = '0, exc_vec_i = '0, swi_vec_i = '0, io_imm_i = '0, pic_vec = '0;
    logic [7:0]  ack_vec_i;
    logic [3:0]  pic_dly = '0;
    logic [23:0] mem_addr_i = '0, addr_o;
    logic [31:0] pwdata_i = '0, prdata_o, rd;
    logic        pready_o, pslverr_o, mio_o, inta_o, disp_valid_o, if_o, ack_valid_i, err;
    xcp_gate_t   gate_i = XCP_GATE_INT;
    xcp_disp_t   disp_o;
    int          errors = 0, comparisons = 0;
    logic [7:0]  vt [15] = '{0, 5, 6, 7, 10, 11, 12, 13, 14, 16, 1, 3, 4, 8, 9};
    xcp_cls_t    ct [15];

    always #50 clk_i = ~clk_i;

    xcp_unit dut (.clk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .boundary_i, .str_window_i, .exc_req_i,
        .exc_vec_i, .dbg_fault_i, .swi_req_i, .swi_vec_i, .interrupt_return_instr_i,
        .gate_i, .task_if_i, .maskable_irq_in_i, .nmi_i, .ack_vec_i, .ack_valid_i,
        .io_req_i, .io_use_dx_i, .io_imm_i, .mem_req_i, .mem_addr_i, .addr_o, .mio_o,
        .inta_o, .disp_valid_o, .disp_o, .if_o);
    xcp_pic_model pic (.clk_i, .arst_n_i, .inta_i(inta_o), .dly_i(pic_dly),
        .vec_i(pic_vec), .ack_valid_o(ack_valid_i), .ack_vec_o(ack_vec_i));

    task automatic results;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1;
        // ready, data and error are taken at the rising edge that samples them
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (pready_o === 1'b1) break;
        end
        if (i == 20) begin errors++; results; end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 0; penable_i <= 0;
    endtask
    // ends every one-cycle pulse, then lets the edge's updates land
    task automatic step;
        @(posedge clk_i);
        boundary_i <= 0; str_window_i <= 0; exc_req_i <= 0; swi_req_i <= 0;
        interrupt_return_instr_i <= 0; io_req_i <= 0; mem_req_i <= 0;
        #1;
    endtask
    task automatic wait_disp(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            if (disp_valid_o === 1'b1) break;
            @(posedge clk_i);
            #1;
        end
        if (i == n) begin errors++; results; end
    endtask
    task automatic no_disp;
        repeat (4) begin chk(disp_valid_o, 0); @(posedge clk_i); #1; end
    endtask
    task automatic chk_disp(input logic [7:0] v, input xcp_cls_t c, input logic [23:0] e);
        chk(disp_o.vec, v);
        chk(disp_o.cls, c);
        chk(disp_o.entry, e);
    endtask

    initial begin
        foreach (ct[k]) ct[k] = k < 10 ? XCP_FAULT : k < 13 ? XCP_TRAP : XCP_ABORT;
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1;
        repeat (3) @(posedge clk_i);
        #1;
        chk(mio_o, 1);
        chk(if_o, 0);
        apb(1, `XCP_TBASE_OFS, 32'h0000_1000);
        apb(0, `XCP_TBASE_OFS, 32'h0);
        chk(rd, 32'h1000);
        apb(1, `XCP_STAT_OFS, 32'hffff_ffff);
        apb(0, `XCP_STAT_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(0, 8'h10, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1, `XCP_DXR_OFS, 32'h5a5a_abcd);
        // stay clear of the system's reserved ports
        @(posedge clk_i); io_req_i <= 1; io_imm_i <= 8'h7f; step;
        chk({mio_o, addr_o}, 25'h000_007f);
        @(posedge clk_i); mem_req_i <= 1; mem_addr_i <= 24'habcdef; step;
        chk({mio_o, addr_o}, 25'h1ab_cdef);
        @(posedge clk_i); io_req_i <= 1; io_use_dx_i <= 1; step;
        chk({mio_o, addr_o}, 25'h000_abcd);
        foreach (vt[k]) begin
            @(posedge clk_i); exc_req_i <= 1; exc_vec_i <= vt[k]; step; wait_disp(1);
            chk_disp(vt[k], ct[k], 24'h1000 + 24'(vt[k]) * 4);
            if (ct[k] != XCP_ABORT) chk(disp_o.ret_at_instr, ct[k] == XCP_FAULT);
        end
        @(posedge clk_i); exc_req_i <= 1; exc_vec_i <= 8'h01; dbg_fault_i <= 1; step;
        wait_disp(1);
        chk(disp_o.cls, XCP_FAULT);
        apb(1, `XCP_CTRL_OFS, 32'h2);
        @(posedge clk_i); dbg_fault_i <= 0; swi_req_i <= 1; swi_vec_i <= 8'hff; step;
        wait_disp(1);
        chk_disp(8'hff, XCP_TRAP, 24'h17f8);
        apb(1, `XCP_CTRL_OFS, 32'h0);
        @(posedge clk_i); maskable_irq_in_i <= 1; boundary_i <= 1; step;
        no_disp;
        chk(inta_o, 0);
        apb(1, `XCP_CTRL_OFS, 32'h1);
        no_disp;
        chk({if_o, inta_o}, 2'b10);
        for (int g = 0; g < 3; g++) begin
            @(posedge clk_i);
            str_window_i <= g == 1; boundary_i <= g != 1; gate_i <= xcp_gate_t'(g);
            pic_vec <= 8'h40 + 8'(g); pic_dly <= 4'(g * 3);
            task_if_i <= g == 2;
            step;
            chk(inta_o, 1);
            wait_disp(12);
            chk_disp(pic_vec, XCP_MASKABLE_IRQ_IN, 24'h1000 + 24'(pic_vec) * 4);
            chk({disp_o.ret_at_instr, if_o}, {1'b0, g != 0});
            @(posedge clk_i); interrupt_return_instr_i <= 1; step;
            chk(if_o, 1);
        end
        // the edge is latched one cycle before a boundary can take it
        @(posedge clk_i); nmi_i <= 1;
        @(posedge clk_i); boundary_i <= 1; step; wait_disp(1);
        chk_disp(8'h02, XCP_NMI, 24'h1008);
        chk({inta_o, if_o}, 2'b00);
        @(posedge clk_i); nmi_i <= 0;
        @(posedge clk_i); nmi_i <= 1; boundary_i <= 1; step;
        no_disp;
        chk(inta_o, 0);
        @(posedge clk_i); interrupt_return_instr_i <= 1; step;
        chk(if_o, 1);
        @(posedge clk_i); boundary_i <= 1; step; wait_disp(1);
        chk(disp_o.vec, 2);
        @(posedge clk_i); interrupt_return_instr_i <= 1; step;
        @(posedge clk_i); boundary_i <= 1; step;
        chk(inta_o, 1);
        wait_disp(12);
        chk(disp_o.vec, pic_vec);
        @(posedge clk_i); maskable_irq_in_i <= 0;
        results;
    end
endmodule // tb
`default_nettype wire
